// file: logic/cbb_pkg.sv
/*
  Shared constants for the carry branch and bit operation block:
  widths, phase encoding, address map boundaries and reset values.
  Assumes a core that presents one decoded instruction per instruction cycle.
*/
package cbb_pkg;

  // ==========================================================================
  // Widths
  localparam int unsigned DATA_W  = 8;
  localparam int unsigned FILE_W  = 8;
  localparam int unsigned ADDR_W  = 12;
  localparam int unsigned BANK_W  = 4;
  localparam int unsigned PC_W    = 21;
  localparam int unsigned BIT_W   = 3;

  // ==========================================================================
  // Address map boundaries
  localparam logic [FILE_W-1:0] ACCESS_LOW_MAX = 8'h5F; // Top of low access half
  localparam logic [BANK_W-1:0] SFR_BANK       = 4'hF;  // Upper access half bank
  localparam logic [BANK_W-1:0] LOW_BANK       = 4'h0;  // Lower access half bank

  // ==========================================================================
  // Reset values
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_RST = 12'h000;
  localparam logic [PC_W-1:0]   PC_RST   = 21'h000000;

  // ==========================================================================
  // Quarter phases of one instruction cycle, Gray along Q1..Q4
  typedef enum logic [1:0] {
    CBB_Q1 = 2'h0,
    CBB_Q2 = 2'h1,
    CBB_Q3 = 2'h3,
    CBB_Q4 = 2'h2
  } cbb_phase_t;

  // Decoded operation held for the cycle
  typedef enum logic [1:0] {
    CBB_OP_NONE   = 2'h0,
    CBB_OP_BRANCH = 2'h1,
    CBB_OP_AND    = 2'h3,
    CBB_OP_CLEAR  = 2'h2
  } cbb_op_t;

endpackage

// file: logic/cbb_addr_resolve.sv
/*
  Data memory address resolver for byte and bit file instructions.
  Assumes the bank select and index base inputs are stable during decode.
*/
`timescale 1ns/1ps
module cbb_addr_resolve
  import cbb_pkg::*;
(
  input  wire logic [cbb_pkg::FILE_W-1:0] file_addr_i,
  input  wire logic                       access_i,
  input  wire logic                       ext_set_i,
  input  wire logic [cbb_pkg::BANK_W-1:0] bank_select_reg_i,
  input  wire logic [cbb_pkg::ADDR_W-1:0] index_base_i,
  output logic      [cbb_pkg::ADDR_W-1:0] addr_o
);

  // ==========================================================================
  // Bank, access half or indexed offset
  logic low_half;
  assign low_half = (file_addr_i <= ACCESS_LOW_MAX);

  always_comb begin
    if (access_i) begin
      addr_o = {bank_select_reg_i, file_addr_i};
    end else if (ext_set_i && low_half) begin
      addr_o = ADDR_W'(index_base_i + {{(ADDR_W-FILE_W){1'b0}}, file_addr_i});
    end else if (low_half) begin
      addr_o = {LOW_BANK, file_addr_i};
    end else begin
      addr_o = {SFR_BANK, file_addr_i};
    end
  end

endmodule // cbb_addr_resolve

// file: logic/cbb_core.sv
/*
  Execution of branch_on_carry, and_work_with_file and clear_file_bit over
  four quarter phases per instruction cycle (decode, read, process, write).
  Assumes the core presents decoded fields, flags and the incremented program
  counter from the Q1 phase onward, on the same clock, and that data memory
  answers a read within the Q2 phase.

  // How it works
  // - Taken branch loads incremented counter plus 2n
  // - Branch only when carry is one
  // - Offset is signed byte, doubled
  // - Taken branch adds one no-operation cycle
  // - AND result to work or file by dest
  // - Dest left unspecified means file register
  // - Access zero, extended, low addresses indexed
*/
`timescale 1ns/1ps
module cbb_core
  import cbb_pkg::*;
(
  input  wire logic                       clk_sys_i,
  input  wire logic                       resetn_i,
  input  wire logic                       instr_valid_i,
  input  wire logic                       branch_on_carry_i,
  input  wire logic                       and_work_with_file_i,
  input  wire logic                       clear_file_bit_i,
  input  wire logic                       dest_file_i,
  input  wire logic                       access_i,
  input  wire logic [cbb_pkg::BIT_W-1:0]  bit_sel_i,
  input  wire logic [cbb_pkg::FILE_W-1:0] file_addr_i,
  input  wire logic [cbb_pkg::DATA_W-1:0] offset_i,
  input  wire logic                       carry_i,
  input  wire logic                       ext_set_i,
  input  wire logic [cbb_pkg::BANK_W-1:0] bank_select_reg_i,
  input  wire logic [cbb_pkg::ADDR_W-1:0] index_base_i,
  input  wire logic [cbb_pkg::DATA_W-1:0] work_i,
  input  wire logic [cbb_pkg::PC_W-1:0]   pc_next_i,
  input  wire logic [cbb_pkg::DATA_W-1:0] mem_rdata_i,
  output logic                            q1_o,
  output logic                            nop_cycle_o,
  output logic      [cbb_pkg::ADDR_W-1:0] mem_addr_o,
  output logic                            mem_rd_o,
  output logic                            mem_wr_o,
  output logic      [cbb_pkg::DATA_W-1:0] mem_wdata_o,
  output logic                            work_we_o,
  output logic      [cbb_pkg::DATA_W-1:0] work_o,
  output logic                            flag_we_o,
  output logic                            neg_o,
  output logic                            zero_o,
  output logic                            pc_load_o,
  output logic      [cbb_pkg::PC_W-1:0]   pc_o
);

  // ==========================================================================
  // Helpers
  function automatic logic [PC_W-1:0] branch_target(input logic [PC_W-1:0]   pc,
                                                      input logic [DATA_W-1:0] n);
    logic [PC_W-1:0] off2;
    off2 = {{(PC_W-DATA_W-1){n[DATA_W-1]}}, n, 1'b0};
    return PC_W'(pc + off2);
  endfunction

  // ==========================================================================
  // Address resolution
  logic [ADDR_W-1:0] file_addr_full;

  cbb_addr_resolve u_addr (
    .file_addr_i       (file_addr_i),
    .access_i          (access_i),
    .ext_set_i         (ext_set_i),
    .bank_select_reg_i (bank_select_reg_i),
    .index_base_i      (index_base_i),
    .addr_o            (file_addr_full)
  );

  // ==========================================================================
  // State
  cbb_phase_t        phase_q,  phase_d;
  cbb_op_t           op_q,     op_d;
  logic              nop_q,    nop_d;
  logic              dest_q,   dest_d;
  logic              taken_q,  taken_d;
  logic [BIT_W-1:0]  bit_q,    bit_d;
  logic [DATA_W-1:0] work_q,   work_d;
  logic [DATA_W-1:0] data_q,   data_d;
  logic [DATA_W-1:0] res_q,    res_d;
  logic [PC_W-1:0]   tgt_q,    tgt_d;
  logic [ADDR_W-1:0] addr_q,   addr_d;
  logic              rd_q,     rd_d;
  logic              wr_q,     wr_d;
  logic              wwe_q,    wwe_d;
  logic              fwe_q,    fwe_d;
  logic              neg_q,    neg_d;
  logic              zero_q,   zero_d;
  logic              pcl_q,    pcl_d;
  logic              q1_q,     q1_d;

  // Next state of phase sequencer and datapath
  always_comb begin
    phase_d = phase_q;
    op_d    = op_q;
    nop_d   = nop_q;
    dest_d  = dest_q;
    taken_d = taken_q;
    bit_d   = bit_q;
    work_d  = work_q;
    data_d  = data_q;
    res_d   = res_q;
    tgt_d   = tgt_q;
    addr_d  = addr_q;
    rd_d    = 1'b0;
    wr_d    = 1'b0;
    wwe_d   = 1'b0;
    fwe_d   = 1'b0;
    neg_d   = neg_q;
    zero_d  = zero_q;
    pcl_d   = 1'b0;
    case (phase_q)
      // Decode: capture fields unless this is the branch refill cycle
      CBB_Q1: begin
        phase_d = CBB_Q2;
        op_d    = CBB_OP_NONE;
        if (instr_valid_i && !nop_q) begin
          if (branch_on_carry_i) begin
            op_d = CBB_OP_BRANCH;
          end else if (and_work_with_file_i) begin
            op_d = CBB_OP_AND;
          end else if (clear_file_bit_i) begin
            op_d = CBB_OP_CLEAR;
          end
          dest_d  = dest_file_i;
          taken_d = carry_i;
          bit_d   = bit_sel_i;
          work_d  = work_i;
          tgt_d   = branch_target(pc_next_i, offset_i);
          addr_d  = file_addr_full;
          rd_d    = and_work_with_file_i | clear_file_bit_i;
          if (branch_on_carry_i) begin
            rd_d = 1'b0;
          end
        end
      end
      // Read file byte
      CBB_Q2: begin
        phase_d = CBB_Q3;
        data_d  = mem_rdata_i;
      end
      // Process and raise write strobes for Q4
      CBB_Q3: begin
        phase_d = CBB_Q4;
        case (op_q)
          CBB_OP_AND: begin
            res_d  = work_q & data_q;
            wr_d   = dest_q;
            wwe_d  = !dest_q;
            fwe_d  = 1'b1;
            neg_d  = res_d[DATA_W-1];
            zero_d = (res_d == DATA_RST);
          end
          CBB_OP_CLEAR: begin
            res_d = data_q & ~(DATA_W'(1) << bit_q);
            wr_d  = 1'b1;
          end
          CBB_OP_BRANCH: begin
            pcl_d = taken_q;
          end
          default: begin
            res_d = res_q;
          end
        endcase
      end
      // Write back; taken branch schedules a no-operation cycle
      CBB_Q4: begin
        phase_d = CBB_Q1;
        nop_d   = (op_q == CBB_OP_BRANCH) && taken_q;
      end
      default: begin
        phase_d = CBB_Q1;
      end
    endcase
    q1_d = (phase_d == CBB_Q1);
  end

  // Registers; reset leaves phase at Q1 with all strobes low
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      phase_q <= CBB_Q1;
      op_q    <= CBB_OP_NONE;
      nop_q   <= 1'b0;
      dest_q  <= 1'b1;
      taken_q <= 1'b0;
      bit_q   <= '0;
      work_q  <= DATA_RST;
      data_q  <= DATA_RST;
      res_q   <= DATA_RST;
      tgt_q   <= PC_RST;
      addr_q  <= ADDR_RST;
      rd_q    <= 1'b0;
      wr_q    <= 1'b0;
      wwe_q   <= 1'b0;
      fwe_q   <= 1'b0;
      neg_q   <= 1'b0;
      zero_q  <= 1'b0;
      pcl_q   <= 1'b0;
      q1_q    <= 1'b1;
    end else begin
      phase_q <= phase_d;
      op_q    <= op_d;
      nop_q   <= nop_d;
      dest_q  <= dest_d;
      taken_q <= taken_d;
      bit_q   <= bit_d;
      work_q  <= work_d;
      data_q  <= data_d;
      res_q   <= res_d;
      tgt_q   <= tgt_d;
      addr_q  <= addr_d;
      rd_q    <= rd_d;
      wr_q    <= wr_d;
      wwe_q   <= wwe_d;
      fwe_q   <= fwe_d;
      neg_q   <= neg_d;
      zero_q  <= zero_d;
      pcl_q   <= pcl_d;
      q1_q    <= q1_d;
    end
  end

  // ==========================================================================
  // Outputs, all straight from flops
  assign q1_o        = q1_q;
  assign nop_cycle_o = nop_q;
  assign mem_addr_o  = addr_q;
  assign mem_rd_o    = rd_q;
  assign mem_wr_o    = wr_q;
  assign mem_wdata_o = res_q;
  assign work_we_o   = wwe_q;
  assign work_o      = res_q;   // Shares result flop; only valid with work_we_o
  assign flag_we_o   = fwe_q;
  assign neg_o       = neg_q;
  assign zero_o      = zero_q;
  assign pc_load_o   = pcl_q;
  assign pc_o        = tgt_q;

endmodule // cbb_core

// file: tb/cbb_core_sva.sv
/*
  Port timing checker for cbb_core.
  Assumes bind onto cbb_core, one clock, inputs held through each instruction.
*/
`timescale 1ns/1ps
module cbb_core_chk
  import cbb_pkg::*;
(
  input wire logic              clk_sys_i,
  input wire logic              resetn_i,
  input wire logic              instr_valid_i,
  input wire logic              branch_on_carry_i,
  input wire logic              and_work_with_file_i,
  input wire logic              clear_file_bit_i,
  input wire logic              dest_file_i,
  input wire logic              access_i,
  input wire logic [BIT_W-1:0]  bit_sel_i,
  input wire logic [FILE_W-1:0] file_addr_i,
  input wire logic [DATA_W-1:0] offset_i,
  input wire logic              carry_i,
  input wire logic              ext_set_i,
  input wire logic [BANK_W-1:0] bank_select_reg_i,
  input wire logic [ADDR_W-1:0] index_base_i,
  input wire logic [DATA_W-1:0] work_i,
  input wire logic [PC_W-1:0]   pc_next_i,
  input wire logic [DATA_W-1:0] mem_rdata_i,
  input wire logic              q1_o,
  input wire logic              nop_cycle_o,
  input wire logic [ADDR_W-1:0] mem_addr_o,
  input wire logic              mem_rd_o,
  input wire logic              mem_wr_o,
  input wire logic [DATA_W-1:0] mem_wdata_o,
  input wire logic              work_we_o,
  input wire logic [DATA_W-1:0] work_o,
  input wire logic              flag_we_o,
  input wire logic              neg_o,
  input wire logic              zero_o,
  input wire logic              pc_load_o,
  input wire logic [PC_W-1:0]   pc_o
);
  // ==========================================================================
  // Helpers: acceptance edge, branch target, indexed address
  logic              acc;
  logic [PC_W-1:0]   tgt;
  logic [ADDR_W-1:0] idx;
  assign acc  = q1_o & instr_valid_i & ~nop_cycle_o;
  assign tgt  = pc_next_i + {{12{offset_i[7]}}, offset_i, 1'b0};
  assign idx  = index_base_i + {4'h0, file_addr_i};

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);

  // Read in Q2, write two cycles later in Q4
  sequence s_rmw;
    mem_rd_o ##2 mem_wr_o;
  endsequence
  sequence s_nop4;
    nop_cycle_o [*4] ##1 !nop_cycle_o;
  endsequence

  // ==========================================================================
  // Assertions
  chk_taken_target: assert property (acc && branch_on_carry_i && carry_i
    |-> ##3 pc_load_o && pc_o == $past(tgt, 3)) else $error("branch target wrong");
  chk_not_taken: assert property (acc && branch_on_carry_i && !carry_i
    |-> ##3 !pc_load_o ##1 !nop_cycle_o) else $error("branch taken without carry");
  chk_nop_cycle: assert property (pc_load_o |=> s_nop4) else $error("nop cycle wrong");
  chk_and_dest: assert property (acc && !branch_on_carry_i && and_work_with_file_i
    |=> mem_rd_o ##2 (flag_we_o && mem_wr_o == $past(dest_file_i, 3)
    && work_we_o != $past(dest_file_i, 3)
    && work_o == ($past(work_i, 3) & $past(mem_rdata_i, 2))))
    else $error("and result routing wrong");
  chk_and_flags: assert property (flag_we_o
    |-> neg_o == work_o[7] && zero_o == (work_o == 8'h00)) else $error("flags wrong");
  chk_clear_rmw: assert property (acc && clear_file_bit_i && !branch_on_carry_i
    && !and_work_with_file_i |=> s_rmw ##0 (!flag_we_o && !work_we_o
    && mem_wdata_o == ($past(mem_rdata_i, 2) & ~(8'h01 << $past(bit_sel_i, 3)))))
    else $error("bit clear wrong");
  chk_addr_bank: assert property (acc && access_i && !branch_on_carry_i
    |=> mem_addr_o == {$past(bank_select_reg_i), $past(file_addr_i)})
    else $error("banked address wrong");
  chk_addr_index: assert property (acc && !access_i && ext_set_i && !branch_on_carry_i
    && file_addr_i <= ACCESS_LOW_MAX |=> mem_addr_o == $past(idx))
    else $error("indexed address wrong");
  // Falling edge avoids the reset-release cycle, where Q1 is held over
  chk_phase_q1: assert property ($fell(q1_o) |-> !q1_o [*3] ##1 q1_o)
    else $error("phase sequence wrong");
  chk_refill_ignored: assert property (q1_o && nop_cycle_o
    |=> !mem_rd_o ##2 (!pc_load_o && !mem_wr_o && !work_we_o))
    else $error("refill cycle not idle");
endmodule // cbb_core_chk

bind cbb_core cbb_core_chk cbb_core_chk_inst (.*);

// file: tb/cbb_core_tb.sv
/*
  Self-checking bench for cbb_core.
  Assumes memory answers with a fixed byte held through each instruction.
*/
`timescale 1ns/1ps
module cbb_core_tb;
  import cbb_pkg::*;
  logic              clk_sys_i, resetn_i, instr_valid_i, carry_i, ext_set_i;
  logic              branch_on_carry_i, and_work_with_file_i, clear_file_bit_i;
  logic              dest_file_i, access_i, q1_o, nop_cycle_o, mem_rd_o, mem_wr_o;
  logic              work_we_o, flag_we_o, neg_o, zero_o, pc_load_o;
  logic [BIT_W-1:0]  bit_sel_i;
  logic [FILE_W-1:0] file_addr_i;
  logic [DATA_W-1:0] offset_i, work_i, mem_rdata_i, mem_wdata_o, work_o;
  logic [BANK_W-1:0] bank_select_reg_i;
  logic [ADDR_W-1:0] index_base_i, mem_addr_o;
  logic [PC_W-1:0]   pc_next_i, pc_o;
  int                miscompares, n_tests;

  cbb_core cbb_core_inst (.*);

  // 20 MHz clock
  initial begin
    clk_sys_i = 1'b0;
    forever #25 clk_sys_i = ~clk_sys_i;
  end

  // ==========================================================================
  // Shared tasks
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Present one instruction, hold it until taken, return in its Q4 cycle
  task automatic issue(input logic [2:0] op, input logic d, a, input logic [7:0] f, w,
                       input logic [7:0] rd, n, input logic c, input logic [2:0] b);
    @(posedge clk_sys_i);
    {branch_on_carry_i, and_work_with_file_i, clear_file_bit_i} <= op;
    {dest_file_i, access_i, carry_i, bit_sel_i} <= {d, a, c, b};
    {file_addr_i, work_i, mem_rdata_i, offset_i} <= {f, w, rd, n};
    instr_valid_i <= 1'b1;
    for (int i = 0; i < 12; i++) begin
      @(negedge clk_sys_i);
      if (q1_o === 1'b1 && nop_cycle_o === 1'b0) break;
    end
    @(posedge clk_sys_i);
    instr_valid_i <= 1'b0;
    repeat (3) @(negedge clk_sys_i);
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_and;
    issue(3'b010, 1'b0, 1'b1, 8'h23, 8'h17, 8'hC2, 8'h00, 1'b0, 3'h0);
    check({work_we_o, mem_wr_o, flag_we_o, zero_o, neg_o, work_o}, {5'b10100, 8'h02});
    issue(3'b010, 1'b1, 1'b1, 8'h23, 8'h80, 8'hC2, 8'h00, 1'b0, 3'h0);
    check({work_we_o, mem_wr_o, flag_we_o, zero_o, neg_o, mem_wdata_o}, {5'b01101, 8'h80});
    issue(3'b010, 1'b1, 1'b1, 8'h23, 8'h0F, 8'hF0, 8'h00, 1'b0, 3'h0);
    check({zero_o, neg_o, mem_wdata_o}, {2'b10, 8'h00});
    $display("and test done");
  endtask

  task automatic t_clear;
    for (int b = 0; b < 8; b++) begin
      issue(3'b001, 1'b1, 1'b1, 8'h23, 8'h00, 8'hFF, 8'h00, 1'b1, 3'(b));
      check({mem_addr_o, mem_wr_o, work_we_o, flag_we_o, mem_wdata_o},
            {12'h523, 3'b100, 8'hFF & ~(8'h01 << b)});
    end
    $display("clear test done");
  endtask

  task automatic t_branch;
    logic [7:0]  offs [3]  = '{8'h7F, 8'h80, 8'h01};
    logic [20:0] dests [3] = '{21'h0010FE, 21'h000F00, 21'h001002};
    for (int k = 0; k < 3; k++) begin
      issue(3'b100, 1'b1, 1'b1, 8'h00, 8'h00, 8'h00, offs[k], 1'b1, 3'h0);
      check({pc_load_o, pc_o}, {1'b1, dests[k]});
      // Offer a branch in the refill cycle; accepting it would stretch the nop
      @(posedge clk_sys_i);
      instr_valid_i <= 1'b1;
      repeat (4) begin
        @(negedge clk_sys_i);
        check(nop_cycle_o, 1);
      end
      @(posedge clk_sys_i);
      instr_valid_i <= 1'b0;
      @(negedge clk_sys_i);
      check(nop_cycle_o, 0);
    end
    issue(3'b100, 1'b1, 1'b1, 8'h00, 8'h00, 8'h00, 8'h7F, 1'b0, 3'h0);
    check(pc_load_o, 0);
    @(negedge clk_sys_i);
    check(nop_cycle_o, 0);
    $display("branch test done");
  endtask

  task automatic t_addr;
    @(posedge clk_sys_i);
    ext_set_i <= 1'b1;
    issue(3'b010, 1'b1, 1'b0, 8'h5F, 8'hFF, 8'h11, 8'h00, 1'b0, 3'h0);
    check(mem_addr_o, 12'h35F);
    issue(3'b010, 1'b1, 1'b0, 8'h60, 8'hFF, 8'h11, 8'h00, 1'b0, 3'h0);
    check(mem_addr_o, 12'hF60);
    @(posedge clk_sys_i);
    ext_set_i <= 1'b0;
    issue(3'b001, 1'b1, 1'b0, 8'h10, 8'h00, 8'h11, 8'h00, 1'b0, 3'h0);
    check(mem_addr_o, 12'h010);
    $display("address test done");
  endtask

  // Main sequence
  initial begin
    {resetn_i, instr_valid_i, carry_i, ext_set_i, dest_file_i, access_i} = 6'h00;
    {branch_on_carry_i, and_work_with_file_i, clear_file_bit_i} = 3'h0;
    {bit_sel_i, file_addr_i, offset_i, work_i, mem_rdata_i} = '0;
    bank_select_reg_i = 4'h5;
    index_base_i = 12'h300;
    pc_next_i = 21'h001000;
    repeat (12) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    t_and();
    t_clear();
    t_branch();
    t_addr();
    conclude();
  end

  // Watchdog, well beyond the roughly 120 cycles the tests need
  initial begin
    repeat (4000) @(posedge clk_sys_i);
    miscompares++;
    conclude();
  end
endmodule // cbb_core_tb
